// ---- rtl/gauge_panel.sv ----
// gauge_panel: key handling, mode selection and display drive for one column
// assumes key inputs are debounced one-cycle pulses synchronous to ref_clk
`timescale 1ns/1ps
module gauge_panel import gauge_pkg::*;
#(
	parameter int LABEL_CYCLES = LABEL_CYC
)
(
	// clock and reset
	input  wire logic                    ref_clk,
	input  wire logic                    rstn,
	// operator keys and encoder
	input  wire panel_keys_t             keys,
	// gauge reading
	input  wire logic signed [VAL_W-1:0] reading,
	// display
	output display_t                     disp,
	output logic [RANGE_W-1:0]           range_ind,
	// settings and judgement
	output logic                         scale_metric,
	output gauge_mode_t                  mode,
	output logic                         over_flag,
	output logic                         under_flag
);

	panel_state_t            state_reg;
	panel_state_t            state_next;
	logic                    metric_reg;
	logic                    metric_next;
	logic [RANGE_W-1:0]      range_reg;
	logic [RANGE_W-1:0]      range_next;
	gauge_mode_t             mode_reg;
	gauge_mode_t             mode_next;
	logic                    sel_upper_reg;
	logic                    sel_upper_next;
	logic [31:0]             timer_reg;
	logic [31:0]             timer_next;
	display_t                disp_reg;
	display_t                disp_next;
	logic                    over_reg;
	logic                    over_next;
	logic                    under_reg;
	logic                    under_next;
	logic signed [VAL_W-1:0] max_val;
	logic signed [VAL_W-1:0] min_val;
	logic signed [VAL_W-1:0] upper_val;
	logic signed [VAL_W-1:0] lower_val;
	logic                    upper_off;
	logic                    lower_off;
	logic signed [VAL_W-1:0] shown;
	logic                    timer_load;

	// ==========================================
	// helpers
	// reset key restarts the extremes in any state, menus included
	peak_tracker #(
		.W       (VAL_W)
	) u_peak (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.reading (reading),
		.restart (keys.reset),
		.max_reg (max_val),
		.min_reg (min_val)
	);

	limit_store u_limits (
		.ref_clk       (ref_clk),
		.rstn          (rstn),
		.edit_en       (state_reg == ST_LIM_EDIT),
		.sel_upper     (sel_upper_reg),
		.rot_up        (keys.rot_up),
		.rot_dn        (keys.rot_dn),
		.upper_reg     (upper_val),
		.lower_reg     (lower_val),
		.upper_off_reg (upper_off),
		.lower_off_reg (lower_off)
	);

	// ==========================================
	// panel state
	always_comb
	begin
		state_next     = state_reg;
		metric_next    = metric_reg;
		range_next     = range_reg;
		mode_next      = mode_reg;
		sel_upper_next = sel_upper_reg;
		timer_load     = 1'b0;
		case (state_reg)
			ST_RUN:
			begin
				if (keys.scale)
					state_next = ST_SCALE;
				else if (keys.range)
					state_next = ST_RANGE;
				else if (keys.mode)
					state_next = ST_MODE;
				else if (keys.limits)
				begin
					state_next = ST_LIM_LABEL;
					timer_load = 1'b1;
				end
			end
			ST_SCALE, ST_RANGE, ST_MODE:
			begin
				// a different key jumps straight to its own setting
				if (keys.scale)
				begin
					if (state_reg == ST_SCALE)
					begin
						metric_next = ~metric_reg;
						range_next  = '0;  // range tables differ between scales
					end
					state_next = ST_SCALE;
				end
				else if (keys.range)
				begin
					if (state_reg == ST_RANGE)
						range_next = (range_reg == (metric_reg ? MM_RANGES : INCH_RANGES)) ? '0
						           : range_reg + 3'h1;
					state_next = ST_RANGE;
				end
				else if (keys.mode)
				begin
					if (state_reg == ST_MODE)
						mode_next = gauge_mode_t'(mode_reg + 2'h1);
					state_next = ST_MODE;
				end
				else if (keys.limits)
				begin
					state_next = ST_LIM_LABEL;
					timer_load = 1'b1;
				end
				// push in run is ignored; only setting states leave on it
				else if (keys.push)
					state_next = ST_RUN;
			end
			ST_LIM_LABEL, ST_LIM_EDIT:
			begin
				if (keys.limits)
				begin
					sel_upper_next = ~sel_upper_reg;
					state_next     = ST_LIM_LABEL;
					timer_load     = 1'b1;
				end
				else if (keys.push)
					state_next = ST_RUN;
				else if (state_reg == ST_LIM_LABEL && timer_reg == 32'h0)
					state_next = ST_LIM_EDIT;
			end
			default:
				state_next = ST_RUN;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			state_reg     <= ST_RUN;
			metric_reg    <= 1'b0;
			range_reg     <= '0;
			mode_reg      <= direct_reading_mode;
			sel_upper_reg <= 1'b1;
		end
		else
		begin
			state_reg     <= state_next;
			metric_reg    <= metric_next;
			range_reg     <= range_next;
			mode_reg      <= mode_next;
			sel_upper_reg <= sel_upper_next;
		end
	end

	// ==========================================
	// label timer; every limits press reloads it, so a toggle restarts the label
	always_comb
	begin
		if (timer_load)
			timer_next = 32'(LABEL_CYCLES);
		else if (timer_reg != 32'h0)
			timer_next = timer_reg - 32'h1;
		else
			timer_next = 32'h0;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			timer_reg <= 32'h0;
		else
			timer_reg <= timer_next;
	end

	// ==========================================
	// measured value by mode
	always_comb
	begin
		case (mode_reg)
			span_hold_mode:      shown = max_val - min_val;
			min_hold_mode:       shown = min_val;
			max_hold_mode:       shown = max_val;
			direct_reading_mode: shown = reading;
			default:             shown = reading;
		endcase
	end

	// ==========================================
	// display
	// built from state_next so a key is answered on the same clock edge that takes it
	always_comb
	begin
		disp_next       = '0;
		disp_next.value = shown;
		disp_next.bar   = shown;
		disp_next.msg   = MSG_VALUE;
		case (state_next)
			ST_SCALE:
			begin
				disp_next.msg   = MSG_SCALE;
				disp_next.value = {{(VAL_W-1){1'b0}}, metric_next};
				disp_next.flash = 1'b1;
			end
			ST_RANGE:
			begin
				disp_next.msg   = MSG_RANGE;
				disp_next.value = {{(VAL_W-RANGE_W){1'b0}}, range_next};
				disp_next.flash = 1'b1;
			end
			ST_MODE:
			begin
				disp_next.msg   = MSG_MODE;
				disp_next.value = {{(VAL_W-2){1'b0}}, mode_next};
				disp_next.flash = 1'b1;
			end
			ST_LIM_LABEL:
				disp_next.msg = sel_upper_next ? MSG_UPPER : MSG_LOWER;
			ST_LIM_EDIT:
			begin
				// shown limit trails the encoder by one clock
				disp_next.flash = 1'b1;
				if (sel_upper_reg)
				begin
					disp_next.msg   = upper_off ? MSG_UPPER_OFF : MSG_VALUE;
					disp_next.value = upper_val;
					disp_next.bar   = upper_off ? BAR_HIGH : upper_val;
				end
				else
				begin
					disp_next.msg   = lower_off ? lower_limit_disabled_msg : MSG_VALUE;
					disp_next.value = lower_val;
					disp_next.bar   = lower_off ? BAR_LOW : lower_val;
				end
			end
			default:
				disp_next.msg = MSG_VALUE;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			disp_reg <= '0;
		end
		else
		begin
			disp_reg <= disp_next;
		end
	end

	// ==========================================
	// judgement on the mode-selected value
	// a limit at full scale still flags; only a disabled one stays silent
	always_comb
	begin
		over_next  = !upper_off && (shown > upper_val);
		under_next = !lower_off && (shown < lower_val);
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			over_reg  <= 1'b0;
			under_reg <= 1'b0;
		end
		else
		begin
			over_reg  <= over_next;
			under_reg <= under_next;
		end
	end

	assign disp         = disp_reg;
	assign range_ind    = range_reg;
	assign scale_metric = metric_reg;
	assign mode         = mode_reg;
	assign over_flag    = over_reg;
	assign under_flag   = under_reg;

endmodule

// ---- rtl/gauge_pkg.sv ----
// gauge_pkg: constants, encodings and carrier types for the gauge panel logic
// assumes one 100 MHz clock, synchronous key pulses and a signed reading
//
// Summary of operation
// - scale key shows scale; another press while flashing swaps inch and metric
// - range key steps to next range; inch has eight, .0002 to .050
// - metric range key cycles millimetre ranges .005 up to 1.00
// - selected range goes to alphanumeric display and range indicator
// - mode key shows mode; presses while flashing step span, min, max, direct
// - limits key shows a limit label; further presses toggle upper and lower
// - upper selected: label then stored upper value on display and bargraph
// - encoder rotation while value flashes adjusts selected limit, displays track
// - upper limit past bargraph top disables it, shows upper-off message
// - lower limit past bargraph bottom disables it, shows lower-off message
// - lower selected: label then stored lower value on display and bargraph
// - encoder push leaves limit setting and keeps adjusted limits
// - direct reading mode shows live input on display and bargraph
// - span mode shows max minus min since last reset key
// - maximum hold shows highest reading since last reset key
// - minimum hold shows lowest reading since reset; reset restarts tracking
package gauge_pkg;

	// ==========================================
	// widths and scale
	localparam int          VAL_W        = 16;
	localparam int          RANGE_W      = 3;
	localparam logic [2:0]  INCH_RANGES  = 3'h7;    // eight inch ranges, last index
	localparam logic [2:0]  MM_RANGES    = 3'h7;    // eight metric ranges, last index
	localparam logic signed [15:0] BAR_HIGH = 16'sh03E8;
	localparam logic signed [15:0] BAR_LOW  = -16'sh03E8;
	localparam logic signed [15:0] UPPER_RST = 16'sh01F4;
	localparam logic signed [15:0] LOWER_RST = -16'sh01F4;

	// ==========================================
	// display timing
	localparam int          LABEL_NS     = 500000000;
	localparam int          CLK_NS       = 10;
	localparam int          LABEL_CYC    = LABEL_NS / CLK_NS;

	// ==========================================
	// message codes on the alphanumeric display
	localparam logic [3:0]  MSG_VALUE    = 4'h0;
	localparam logic [3:0]  MSG_SCALE    = 4'h1;
	localparam logic [3:0]  MSG_RANGE    = 4'h2;
	localparam logic [3:0]  MSG_MODE     = 4'h3;
	localparam logic [3:0]  MSG_UPPER    = 4'h4;
	localparam logic [3:0]  MSG_LOWER    = 4'h5;
	localparam logic [3:0]  MSG_UPPER_OFF = 4'h6;
	localparam logic [3:0]  lower_limit_disabled_msg = 4'h7;

	typedef enum logic [1:0]
	{
		span_hold_mode      = 2'h0,
		min_hold_mode       = 2'h1,
		max_hold_mode       = 2'h2,
		direct_reading_mode = 2'h3
	} gauge_mode_t;

	// gray-coded panel states along show -> edit path
	typedef enum logic [2:0]
	{
		ST_RUN       = 3'h0,
		ST_SCALE     = 3'h1,
		ST_RANGE     = 3'h3,
		ST_MODE      = 3'h2,
		ST_LIM_LABEL = 3'h6,
		ST_LIM_EDIT  = 3'h7
	} panel_state_t;

	typedef struct packed
	{
		logic scale;
		logic range;
		logic mode;
		logic limits;
		logic reset;
		logic push;
		logic rot_up;
		logic rot_dn;
	} panel_keys_t;

	typedef struct packed
	{
		logic [3:0]              msg;
		logic                    flash;
		logic signed [VAL_W-1:0] value;
		logic signed [VAL_W-1:0] bar;
	} display_t;

endpackage

// ---- rtl/peak_tracker.sv ----
// peak_tracker: running max and min of the reading since the reset key
// assumes reading is valid every clock
`timescale 1ns/1ps
module peak_tracker import gauge_pkg::*;
#(
	parameter int W = VAL_W
)
(
	// clock and reset
	input  wire logic                ref_clk,
	input  wire logic                rstn,
	// reading and restart
	input  wire logic signed [W-1:0] reading,
	input  wire logic                restart,
	// tracked extremes
	output logic signed [W-1:0]      max_reg,
	output logic signed [W-1:0]      min_reg
);

	logic signed [W-1:0] max_next;
	logic signed [W-1:0] min_next;

	// ==========================================
	// tracking
	always_comb
	begin
		max_next = max_reg;
		min_next = min_reg;
		if (restart)
		begin
			max_next = reading;
			min_next = reading;
		end
		else
		begin
			if (reading > max_reg)
				max_next = reading;
			if (reading < min_reg)
				min_next = reading;
		end
	end

	// reset clears both extremes to zero; only the reset key loads them from the reading
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			max_reg <= '0;
			min_reg <= '0;
		end
		else
		begin
			max_reg <= max_next;
			min_reg <= min_next;
		end
	end

endmodule

// ---- rtl/limit_store.sv ----
// limit_store: upper and lower limits with encoder adjustment and disable
// assumes rot_up and rot_dn are single-cycle detent pulses
`timescale 1ns/1ps
module limit_store import gauge_pkg::*;
(
	// clock and reset
	input  wire logic                    ref_clk,
	input  wire logic                    rstn,
	// adjustment
	input  wire logic                    edit_en,
	input  wire logic                    sel_upper,
	input  wire logic                    rot_up,
	input  wire logic                    rot_dn,
	// stored limits
	output logic signed [VAL_W-1:0]      upper_reg,
	output logic signed [VAL_W-1:0]      lower_reg,
	output logic                         upper_off_reg,
	output logic                         lower_off_reg
);

	logic signed [VAL_W-1:0] upper_next;
	logic signed [VAL_W-1:0] lower_next;
	logic                    upper_off_next;
	logic                    lower_off_next;

	// ==========================================
	// adjustment
	always_comb
	begin
		upper_next     = upper_reg;
		lower_next     = lower_reg;
		upper_off_next = upper_off_reg;
		lower_off_next = lower_off_reg;
		if (edit_en && sel_upper)
		begin
			if (rot_up && !upper_off_reg)
			begin
				if (upper_reg >= BAR_HIGH)
					upper_off_next = 1'b1;
				else
					upper_next = upper_reg + 16'sh0001;
			end
			else if (rot_dn)
			begin
				if (upper_off_reg)
					upper_off_next = 1'b0;
				else if (upper_reg > lower_reg)
					upper_next = upper_reg - 16'sh0001;
			end
		end
		else if (edit_en)
		begin
			if (rot_dn && !lower_off_reg)
			begin
				if (lower_reg <= BAR_LOW)
					lower_off_next = 1'b1;
				else
					lower_next = lower_reg - 16'sh0001;
			end
			else if (rot_up)
			begin
				if (lower_off_reg)
					lower_off_next = 1'b0;
				else if (lower_reg < upper_reg)
					lower_next = lower_reg + 16'sh0001;
			end
		end
	end

	// values persist when editing ends
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			upper_reg     <= UPPER_RST;
			lower_reg     <= LOWER_RST;
			upper_off_reg <= 1'b0;
			lower_off_reg <= 1'b0;
		end
		else
		begin
			upper_reg     <= upper_next;
			lower_reg     <= lower_next;
			upper_off_reg <= upper_off_next;
			lower_off_reg <= lower_off_next;
		end
	end

endmodule

// ---- tb/gauge_panel_asserts.sv ----
// gauge_panel_asserts: port-level checks on gauge_panel
// assumes bind onto gauge_panel, one clock, sync active-low reset
`timescale 1ns/1ps
module gauge_panel_asserts import gauge_pkg::*;
#(
	parameter int LABEL_CYCLES = 4
)
(
	// clock and reset
	input wire logic                    ref_clk,
	input wire logic                    rstn,
	// operator side
	input wire panel_keys_t             keys,
	input wire logic signed [VAL_W-1:0] reading,
	// display and settings
	input wire display_t                disp,
	input wire logic [RANGE_W-1:0]      range_ind,
	input wire logic                    scale_metric,
	input wire gauge_mode_t             mode,
	input wire logic                    over_flag,
	input wire logic                    under_flag
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	// ==========
	// settings
	property p_scale;
		keys == 8'h80 && disp.msg == MSG_SCALE && disp.flash |=> scale_metric != $past(scale_metric);
	endproperty
	a_scale: assert property (p_scale) else $error("scale not swapped");
	property p_range;
		keys == 8'h40 && disp.msg == MSG_RANGE && disp.flash |=> range_ind == $past(range_ind) + 3'h1;
	endproperty
	a_range: assert property (p_range) else $error("range not stepped");
	property p_mode;
		keys == 8'h20 && disp.msg == MSG_MODE && disp.flash |=> mode == $past(mode) + 2'h1;
	endproperty
	a_mode: assert property (p_mode) else $error("mode not stepped");
	property p_toggle;
		keys == 8'h10 && disp.msg == MSG_UPPER |=> disp.msg == MSG_LOWER;
	endproperty
	a_toggle: assert property (p_toggle) else $error("limit label not toggled");
	property p_label;
		keys == 8'h10 |=> (disp.msg == MSG_UPPER || disp.msg == MSG_LOWER) && !disp.flash;
	endproperty
	a_label: assert property (p_label) else $error("limits key showed no label");

	// ==========
	// limit editing
	property p_track;
		disp.msg == MSG_VALUE && disp.flash |-> disp.bar == disp.value;
	endproperty
	a_track: assert property (p_track) else $error("bar not tracking");
	property p_upper_off;
		keys == 8'h02 && disp.msg == MSG_VALUE && disp.flash && disp.value == BAR_HIGH
			|-> ##2 disp.msg == MSG_UPPER_OFF;
	endproperty
	a_upper_off: assert property (p_upper_off) else $error("upper not disabled");
	property p_push;
		keys == 8'h04 && disp.flash |=> disp.msg == MSG_VALUE && !disp.flash;
	endproperty
	a_push: assert property (p_push) else $error("push did not exit");

	// ==========
	// readings; past-cycle terms keep mode changes and reset out
	property p_direct;
		mode == direct_reading_mode && $past(mode) == direct_reading_mode && $past(rstn)
			&& disp.msg == MSG_VALUE && !disp.flash && $past(disp.msg) == MSG_VALUE && !$past(disp.flash)
			|-> disp.value == $past(reading) && disp.bar == disp.value;
	endproperty
	a_direct: assert property (p_direct) else $error("direct value wrong");
	property p_max;
		mode == max_hold_mode && $past(mode) == max_hold_mode && $past(rstn, 2) && disp.msg == MSG_VALUE
			&& $past(disp.msg) == MSG_VALUE && !$past(keys.reset) && !$past(keys.reset, 2)
			&& !disp.flash && !$past(disp.flash)
			|-> $signed(disp.value) >= $signed($past(disp.value));
	endproperty
	a_max: assert property (p_max) else $error("max fell");

	c_upper_off: cover property (disp.msg == MSG_UPPER_OFF);
	c_lower_off: cover property (disp.msg == lower_limit_disabled_msg);
	c_span: cover property (mode == span_hold_mode && disp.msg == MSG_VALUE);
endmodule

// ---- tb/operator_model.sv ----
// operator_model: panel operator pressing keys and presenting readings
// assumes keys are sampled on the rising edge of ref_clk
`timescale 1ns/1ps
module operator_model import gauge_pkg::*;
(
	// clock
	input wire logic                ref_clk,
	// panel and gauge
	output panel_keys_t             keys,
	output logic signed [VAL_W-1:0] reading
);
	initial
	begin
		keys = '0;
		reading = '0;
	end

	// one-cycle pulse; a large gap plays a slow operator
	task automatic press(input logic [7:0] k, input int gap);
		@(posedge ref_clk);
		#1 keys = k;
		@(posedge ref_clk);
		#1 keys = '0;
		// every return lands just after an edge, never on it
		repeat (gap)
		begin
			@(posedge ref_clk);
			#1;
		end
	endtask

	task automatic set(input logic signed [VAL_W-1:0] v);
		@(posedge ref_clk);
		#1 reading = v;
		repeat (3) @(posedge ref_clk);
		#1;
	endtask
endmodule

// ---- tb/testbench.sv ----
// testbench: drives gauge_panel through the operator model and judges it
// assumes gauge_pkg compiled first; label time shortened to 4 cycles
`timescale 1ns/1ps
module testbench import gauge_pkg::*;
;
	logic                    ref_clk = 1'b0;
	logic                    rstn = 1'b0;
	panel_keys_t             keys;
	logic signed [VAL_W-1:0] reading;
	display_t                disp;
	logic [RANGE_W-1:0]      range_ind;
	logic                    scale_metric;
	gauge_mode_t             mode;
	logic                    over_flag;
	logic                    under_flag;
	int                      errors = 0;
	int                      samples_checked = 0;
	localparam logic [7:0]   SCALE_KEY = 8'h80;
	localparam logic [7:0]   RANGE_KEY = 8'h40;
	localparam logic [7:0]   MODE_KEY = 8'h20;
	localparam logic [7:0]   LIMIT_KEY = 8'h10;
	localparam logic [7:0]   CLEAR_KEY = 8'h08;
	localparam logic [7:0]   PUSH_KEY = 8'h04;
	localparam logic [7:0]   TURN_UP = 8'h02;
	localparam logic [7:0]   TURN_DN = 8'h01;

	always #5 ref_clk = ~ref_clk;

	operator_model i_op (.ref_clk(ref_clk), .keys(keys), .reading(reading));
	gauge_panel #(.LABEL_CYCLES(4)) i_gauge_panel (.ref_clk(ref_clk), .rstn(rstn), .keys(keys),
		.reading(reading), .disp(disp), .range_ind(range_ind), .scale_metric(scale_metric),
		.mode(mode), .over_flag(over_flag), .under_flag(under_flag));

	// ==========
	// helpers
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic turn(input logic [7:0] k, input int n);
		repeat (n) i_op.press(k, 0);
		// shown limit trails the encoder by one clock
		@(posedge ref_clk);
		#1;
	endtask

	task automatic report_and_stop;
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ==========
	// scenarios
	task automatic t_range;
		i_op.press(RANGE_KEY, 0);
		chk("msg", 16'(disp.msg), 16'(MSG_RANGE));
		chk("range", 16'(range_ind), 16'h0000);
		for (int i = 1; i <= 8; i++)
		begin
			i_op.press(RANGE_KEY, 0);
			chk("range", 16'(range_ind), 16'(i % 8));
		end
		i_op.press(PUSH_KEY, 0);
	endtask

	task automatic t_scale;
		i_op.press(SCALE_KEY, 0);
		chk("msg", 16'(disp.msg), 16'(MSG_SCALE));
		chk("scale", 16'(scale_metric), 16'h0000);
		i_op.press(SCALE_KEY, 3);
		chk("scale", 16'(scale_metric), 16'h0001);
		i_op.press(PUSH_KEY, 0);
		chk("flash", 16'(disp.flash), 16'h0000);
	endtask

	task automatic t_mode;
		i_op.press(MODE_KEY, 0);
		chk("mode", 16'(mode), 16'h0003);
		for (int i = 0; i < 4; i++)
		begin
			i_op.press(MODE_KEY, 0);
			chk("mode", 16'(mode), 16'(i));
		end
		i_op.press(PUSH_KEY, 0);
	endtask

	task automatic t_limits;
		i_op.press(LIMIT_KEY, 0);
		chk("msg", 16'(disp.msg), 16'(MSG_UPPER));
		i_op.press(LIMIT_KEY, 0);
		chk("msg", 16'(disp.msg), 16'(MSG_LOWER));
		i_op.press(LIMIT_KEY, 0);
		chk("msg", 16'(disp.msg), 16'(MSG_UPPER));
		repeat (8) @(posedge ref_clk);
		#1;
		chk("upper", disp.value, UPPER_RST);
		chk("bar", disp.bar, UPPER_RST);
		turn(TURN_UP, 500);
		chk("upper", disp.value, BAR_HIGH);
		turn(TURN_UP, 1);
		chk("msg", 16'(disp.msg), 16'(MSG_UPPER_OFF));
		i_op.press(PUSH_KEY, 0);
		i_op.press(LIMIT_KEY, 0);
		i_op.press(LIMIT_KEY, 0);
		chk("msg", 16'(disp.msg), 16'(MSG_LOWER));
		repeat (8) @(posedge ref_clk);
		#1;
		chk("lower", disp.value, LOWER_RST);
		chk("bar", disp.bar, LOWER_RST);
		turn(TURN_DN, 500);
		chk("lower", disp.bar, BAR_LOW);
		turn(TURN_DN, 1);
		chk("msg", 16'(disp.msg), 16'(lower_limit_disabled_msg));
		turn(TURN_UP, 1);
		chk("msg", 16'(disp.msg), 16'(MSG_VALUE));
		i_op.press(PUSH_KEY, 0);
		chk("flash", 16'(disp.flash), 16'h0000);
	endtask

	task automatic t_live;
		i_op.set(16'sh00C8);
		chk("value", disp.value, 16'sh00C8);
		chk("bar", disp.bar, 16'sh00C8);
		i_op.set(16'sh04B0);
		chk("over", 16'(over_flag), 16'h0000);
		i_op.set(-16'sh04B0);
		chk("under", 16'(under_flag), 16'h0001);
		// re-enable the upper limit at full scale, then exceed it
		i_op.press(LIMIT_KEY, 0);
		i_op.press(LIMIT_KEY, 8);
		chk("msg", 16'(disp.msg), 16'(MSG_UPPER_OFF));
		turn(TURN_DN, 1);
		chk("upper", disp.value, BAR_HIGH);
		i_op.press(PUSH_KEY, 0);
		i_op.set(16'sh04B0);
		chk("over", 16'(over_flag), 16'h0001);
		chk("under", 16'(under_flag), 16'h0000);
	endtask

	task automatic t_peak;
		turn(MODE_KEY, 2);
		i_op.press(PUSH_KEY, 0);
		i_op.set(16'sh000A);
		i_op.press(CLEAR_KEY, 2);
		i_op.set(16'sh0028);
		i_op.set(-16'sh0014);
		i_op.set(16'sh001E);
		chk("span", disp.value, 16'sh003C);
		turn(MODE_KEY, 2);
		i_op.press(PUSH_KEY, 2);
		chk("min", disp.value, -16'sh0014);
		turn(MODE_KEY, 2);
		i_op.press(PUSH_KEY, 2);
		chk("max", disp.value, 16'sh0028);
		i_op.press(CLEAR_KEY, 3);
		chk("max", disp.value, 16'sh001E);
	endtask

	initial
	begin
		repeat (20000) @(posedge ref_clk);
		errors++;
		$display("watchdog expired");
		report_and_stop();
	end

	initial
	begin
		repeat (2) @(posedge ref_clk);
		#1 rstn = 1'b1;
		chk("mode", 16'(mode), 16'h0003);
		chk("scale", 16'(scale_metric), 16'h0000);
		t_range();
		t_scale();
		t_range();
		t_mode();
		t_limits();
		t_live();
		t_peak();
		report_and_stop();
	end
endmodule

bind gauge_panel gauge_panel_asserts #(.LABEL_CYCLES(LABEL_CYCLES)) i_chk (.ref_clk(ref_clk), .rstn(rstn),
	.keys(keys), .reading(reading), .disp(disp), .range_ind(range_ind), .scale_metric(scale_metric),
	.mode(mode), .over_flag(over_flag), .under_flag(under_flag));
